// File: logic/dsc_serial_port.sv
// Purpose: Serial write port and command decoder of a dual voltage DAC
// Assumes: Link pins sampled by sys_clk; link clock well below sys_clk/2
// Notes: Registers over Avalon-MM with one wait state
// Notes on behaviour
// - Falling frame sync starts a frame and arms the shift register.
// - Data is sampled on each falling serial clock while sync is low.
// - The 32nd falling edge takes the last bit and executes the command; with chain enabled, sync rising executes it.
// - First four bits ignored; next four form the command field.
// - Data word of resolution width follows the address, then padding.
// - Command 0 writes the input register only.
// - Command 1 copies input register to output register.
// - Command 2 writes input then loads every channel's output.
// - Command 3 writes and updates the addressed channel together.
// - Command 4 sets power mode of the selected channels.
// - Command 5 loads clear code; command 6 loads strobe mask.
// - Command 7 resets to power-on state; command 8 sets chain enable.
// - Command 9 sets aux direction and value; code 15 is reserved.
// - Address 0 is A, 1 is B, 15 is both, others unused.
// - Sync rising before the 32nd edge discards the frame.
// - Data word is an unsigned straight-binary code.
// - Top four bits drive 15 segments; low twelve drive the ladder.
// - Load strobe low moves pending input data to the outputs.
// - Clear falling edge loads clear code; strobe ignored while low.
// - Power mode 00 normal, 01 1k, 10 100k, 11 three-state.
// - Extra clocks shift earlier bits out on rising edges.
`timescale 1ns/1ps
module dsc_serial_port #(
	parameter int RES = 16,
	parameter logic POR_MID = 1'b0
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire dsc_pkg::dsc_link_s link,
	input wire logic load_strobe_n,
	input wire logic async_clear_n,
	output logic serial_data_out,
	input wire logic [1:0] aux_io_in,
	output logic [1:0] aux_io_out,
	output logic [1:0] aux_io_oe,
	output dsc_pkg::dsc_chan_s [1:0] chan,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	localparam int MR = dsc_pkg::MAX_RES;
	localparam int NCH = dsc_pkg::NCH;

	function automatic logic [1:0] chan_sel(input logic [3:0] a);
		chan_sel = (a == dsc_pkg::ADDR_A) ? 2'h1 :
			(a == dsc_pkg::ADDR_B) ? 2'h2 :
			(a == dsc_pkg::ADDR_ALL) ? 2'h3 : 2'h0;
	endfunction

	function automatic logic [RES-1:0] clr_value(input logic [1:0] c);
		clr_value = (c == dsc_pkg::CLR_MID) ? RES'(1) << (RES - 1) :
			(c == dsc_pkg::CLR_FULL) ? {RES{1'b1}} : RES'(0);
	endfunction

	function automatic logic [MR-1:0] align(input logic [RES-1:0] v);
		align = MR'(v) << (MR - RES);
	endfunction

	// Pin synchronisers
	logic [4:0] pin_raw;
	logic [4:0] pin_s1;
	logic [4:0] pin_s2;
	logic [4:0] pin_s3;
	logic [1:0] aux_s1;
	logic [1:0] aux_s2;
	assign pin_raw = {link.sync_n, link.sclk, link.sdin, load_strobe_n,
		async_clear_n};

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1 <= dsc_pkg::PIN_RST;
			pin_s2 <= dsc_pkg::PIN_RST;
			pin_s3 <= dsc_pkg::PIN_RST;
			aux_s1 <= 2'h0;
			aux_s2 <= 2'h0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			aux_s1 <= aux_io_in;
			aux_s2 <= aux_s1;
		end
	end

	wire sync_lo = ~pin_s2[4];
	wire sync_fall = ~pin_s2[4] & pin_s3[4];
	wire sync_rise = pin_s2[4] & ~pin_s3[4];
	wire sclk_fall = ~pin_s2[3] & pin_s3[3];
	wire sclk_rise = pin_s2[3] & ~pin_s3[3];
	wire sd = pin_s2[2];
	wire clr_lo = ~pin_s2[0];
	wire clr_fall = ~pin_s2[0] & pin_s3[0];
	wire load_strobe_n_act = ~pin_s2[1] & pin_s2[0];

	// Control state
	logic port_en;
	logic chain_en;
	logic [1:0] clr_code;
	logic [1:0] load_strobe_n_mask;
	logic [1:0] aux_dir;
	logic [1:0] aux_val;
	logic [1:0] pd_mode [NCH];
	logic [RES-1:0] in_reg [NCH];
	logic [RES-1:0] dac_reg [NCH];
	logic [1:0] pend;
	logic [7:0] frame_cnt;
	logic [7:0] abort_cnt;

	// Frame engine
	dsc_pkg::dsc_st_e st;
	dsc_pkg::dsc_st_e next_st;
	logic [31:0] shreg;
	logic [5:0] count;
	logic frame_chain;

	wire shift_edge = sclk_fall & sync_lo & ~sync_rise;
	wire last_edge = shift_edge & (count == dsc_pkg::LAST_BIT);
	wire abort = (st == dsc_pkg::ST_SHIFT) & sync_rise;
	wire exec_std = (st == dsc_pkg::ST_SHIFT) & last_edge & ~frame_chain;
	wire exec_chain = (st == dsc_pkg::ST_DONE) & sync_rise & frame_chain;
	wire exec = exec_std | exec_chain;
	wire [31:0] shin = {shreg[30:0], sd};
	wire [31:0] word = exec_std ? shin : shreg;
	wire [3:0] cmd = word[dsc_pkg::CMD_HI:dsc_pkg::CMD_LO];
	wire [3:0] adr = word[dsc_pkg::ADR_HI:dsc_pkg::ADR_LO];
	wire [RES-1:0] data = word[dsc_pkg::DATA_HI -: RES];
	wire [1:0] sel = chan_sel(adr);
	wire [RES-1:0] por_code = POR_MID ? RES'(1) << (RES - 1) : RES'(0);

	always_comb begin
		next_st = st;
		case (st)
			dsc_pkg::ST_IDLE: begin
				if (sync_fall && port_en) begin
					next_st = dsc_pkg::ST_SHIFT;
				end
			end
			dsc_pkg::ST_SHIFT: begin
				if (sync_rise) begin
					next_st = dsc_pkg::ST_IDLE;
				end else if (last_edge) begin
					next_st = dsc_pkg::ST_DONE;
				end
			end
			dsc_pkg::ST_DONE: begin
				if (sync_rise) begin
					next_st = dsc_pkg::ST_IDLE;
				end
			end
			default: next_st = dsc_pkg::ST_IDLE;
		endcase
	end

	wire shifting = (st == dsc_pkg::ST_SHIFT) |
		((st == dsc_pkg::ST_DONE) & frame_chain);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= dsc_pkg::ST_IDLE;
			shreg <= 32'h0;
			count <= 6'h00;
			frame_chain <= 1'b0;
		end else begin
			st <= next_st;
			// Mode is fixed per frame so one frame never executes twice
			if (st == dsc_pkg::ST_IDLE) begin
				frame_chain <= chain_en;
			end
			if ((st == dsc_pkg::ST_IDLE) || abort) begin
				shreg <= 32'h0;
				count <= 6'h00;
			end else if (shift_edge && shifting) begin
				shreg <= shin;
				if (count != dsc_pkg::FULL_CNT) begin
					count <= count + 6'h01;
				end
			end
		end
	end

	// Chain output moves on rising link clock
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			serial_data_out <= 1'b0;
		end else if (!chain_en) begin
			serial_data_out <= 1'b0;
		end else if (sclk_rise && sync_lo) begin
			serial_data_out <= shreg[31];
		end
	end

	// Channel registers
	logic [RES-1:0] next_in [NCH];
	logic [RES-1:0] next_dac [NCH];
	logic [1:0] next_pend;

	always_comb begin
		next_in = in_reg;
		next_dac = dac_reg;
		next_pend = pend;
		for (int i = 0; i < NCH; i++) begin
			if (load_strobe_n_act && pend[i] && !load_strobe_n_mask[i]) begin
				next_dac[i] = in_reg[i];
				next_pend[i] = 1'b0;
			end
			if (exec) begin
				case (cmd)
					dsc_pkg::CMD_WR_IN: begin
						if (sel[i]) begin
							next_in[i] = data;
							next_pend[i] = 1'b1;
						end
					end
					dsc_pkg::CMD_UPD: begin
						if (sel[i]) begin
							next_dac[i] = in_reg[i];
							next_pend[i] = 1'b0;
						end
					end
					dsc_pkg::CMD_WR_ALL: begin
						if (sel[i]) begin
							next_in[i] = data;
						end
						next_dac[i] = sel[i] ? data : in_reg[i];
						next_pend[i] = 1'b0;
					end
					dsc_pkg::CMD_WR_UPD: begin
						if (sel[i]) begin
							next_in[i] = data;
							next_dac[i] = data;
							next_pend[i] = 1'b0;
						end
					end
					dsc_pkg::CMD_RESET: begin
						next_in[i] = por_code;
						next_dac[i] = por_code;
						next_pend[i] = 1'b0;
					end
					default: begin
					end
				endcase
			end
			if (clr_fall) begin
				next_in[i] = clr_value(clr_code);
				next_dac[i] = clr_value(clr_code);
				next_pend[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NCH; i++) begin
				in_reg[i] <= RES'(0);
				dac_reg[i] <= RES'(0);
			end
			pend <= 2'h0;
		end else begin
			in_reg <= next_in;
			dac_reg <= next_dac;
			pend <= next_pend;
		end
	end

	// Mode and configuration registers
	wire do_pwr = exec & (cmd == dsc_pkg::CMD_PWR);
	wire do_rst = exec & (cmd == dsc_pkg::CMD_RESET);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pd_mode[0] <= 2'h0;
			pd_mode[1] <= 2'h0;
			clr_code <= dsc_pkg::CLR_ZERO;
			load_strobe_n_mask <= 2'h0;
			chain_en <= 1'b0;
			aux_dir <= 2'h0;
			aux_val <= 2'h0;
		end else if (do_rst) begin
			pd_mode[0] <= 2'h0;
			pd_mode[1] <= 2'h0;
			clr_code <= dsc_pkg::CLR_ZERO;
			load_strobe_n_mask <= 2'h0;
			chain_en <= 1'b0;
			aux_dir <= 2'h0;
			aux_val <= 2'h0;
		end else if (exec) begin
			for (int i = 0; i < NCH; i++) begin
				if (do_pwr && word[i]) begin
					pd_mode[i] <= word[dsc_pkg::PD_HI:dsc_pkg::PD_LO];
				end
			end
			if (cmd == dsc_pkg::CMD_CLR_CODE) begin
				clr_code <= word[1:0];
			end
			if (cmd == dsc_pkg::CMD_MASK) begin
				load_strobe_n_mask <= word[1:0];
			end
			if (cmd == dsc_pkg::CMD_CHAIN) begin
				chain_en <= word[dsc_pkg::CHAIN_BIT];
			end
			if (cmd == dsc_pkg::CMD_AUX) begin
				aux_dir <= word[dsc_pkg::AUX_DIR_LO +: 2];
				aux_val <= word[dsc_pkg::AUX_VAL_LO +: 2];
			end
		end
	end

	assign aux_io_out = aux_val;
	assign aux_io_oe = aux_dir;

	// Channel outputs and segment decode
	for (genvar g = 0; g < NCH; g++) begin : g_chan
		logic [MR-1:0] al;
		logic [14:0] seg;
		assign al = align(dac_reg[g]);
		dsc_therm_dec u_therm (
			.sys_clk(sys_clk),
			.arst_n(arst_n),
			.msb(al[MR-1 -: 4]),
			.seg(seg)
		);
		assign chan[g].pd_mode = pd_mode[g];
		assign chan[g].code = MR'(dac_reg[g]);
		assign chan[g].segments = seg;
		assign chan[g].ladder = al[dsc_pkg::LADDER_W-1:0];
	end

	// Frame statistics
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			frame_cnt <= 8'h00;
			abort_cnt <= 8'h00;
		end else begin
			if (exec) begin
				frame_cnt <= frame_cnt + 8'h01;
			end
			if (abort) begin
				abort_cnt <= abort_cnt + 8'h01;
			end
		end
	end

	// Avalon-MM slave, one wait state
	logic ack;
	wire req = avs_read | avs_write;
	wire wr_ctrl = avs_write & ack & (avs_address == dsc_pkg::REG_CTRL);
	wire [31:0] status = {frame_cnt, abort_cnt, pend, aux_s2, aux_dir,
		load_strobe_n_mask, clr_code, pd_mode[1], pd_mode[0],
		(st != dsc_pkg::ST_IDLE), chain_en};
	wire [31:0] rd_mux =
		(avs_address == dsc_pkg::REG_CTRL) ? {31'h0, port_en} :
		(avs_address == dsc_pkg::REG_STATUS) ? status :
		(avs_address == dsc_pkg::REG_CHAN_A) ?
			{align(in_reg[0]), align(dac_reg[0])} :
		(avs_address == dsc_pkg::REG_CHAN_B) ?
			{align(in_reg[1]), align(dac_reg[1])} : 32'h0;
	assign avs_waitrequest = req & ~ack;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack <= 1'b0;
			avs_readdata <= 32'h0;
			port_en <= dsc_pkg::CTRL_RST[dsc_pkg::CTRL_EN_BIT];
		end else begin
			ack <= req & ~ack;
			if (avs_read && !ack) begin
				avs_readdata <= rd_mux;
			end
			if (wr_ctrl) begin
				port_en <= avs_writedata[dsc_pkg::CTRL_EN_BIT];
			end
		end
	end

	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	abort_discard_a: assert property (abort |=> st == dsc_pkg::ST_IDLE &&
		count == 6'h00 && frame_cnt == $past(frame_cnt))
		else $error("Cut frame not discarded");
	shift_in_a: assert property ((st == dsc_pkg::ST_SHIFT) && shift_edge
		|=> shreg[0] == $past(sd) && count == $past(count) + 6'h01)
		else $error("Bit not shifted in");
	exec_edge_a: assert property (exec_std |-> count == 6'h1f &&
		st == dsc_pkg::ST_SHIFT)
		else $error("Execute not on 32nd edge");
	write_input_a: assert property (exec && cmd == 4'h0 && sel[0] &&
		!clr_fall && !load_strobe_n_act |=> in_reg[0] == $past(data) &&
		$stable(dac_reg[0]) && pend[0])
		else $error("Input write changed output");
	update_copy_a: assert property (exec && cmd == 4'h1 && sel[1] &&
		!clr_fall |=> dac_reg[1] == $past(in_reg[1]))
		else $error("Update did not copy input");
	load_all_a: assert property (exec && cmd == 4'h2 && sel == 2'h1 &&
		!clr_fall |=> dac_reg[0] == $past(data) &&
		dac_reg[1] == $past(in_reg[1]))
		else $error("Software load failed");
	write_update_a: assert property (exec && cmd == 4'h3 && sel[0] &&
		!clr_fall |=> dac_reg[0] == $past(data) &&
		in_reg[0] == $past(data))
		else $error("Write and update failed");
	power_mode_a: assert property (exec && cmd == 4'h4 && word[1]
		|=> pd_mode[1] == $past(word[9:8]))
		else $error("Power mode not applied");
	mask_load_a: assert property (exec && cmd == 4'h6 |=>
		load_strobe_n_mask == $past(word[1:0]))
		else $error("Mask not loaded");
	soft_reset_a: assert property (do_rst |=> chain_en == 1'b0 &&
		pd_mode[0] == 2'h0 && pd_mode[1] == 2'h0)
		else $error("Software reset incomplete");
	clear_load_a: assert property (clr_fall |=>
		dac_reg[0] == clr_value($past(clr_code)) &&
		in_reg[1] == clr_value($past(clr_code)))
		else $error("Clear code not loaded");
	clear_block_a: assert property (clr_lo && !exec && !clr_fall
		|=> $stable(dac_reg[0]) && $stable(dac_reg[1]))
		else $error("Strobe acted while clear low");
	chain_out_a: assert property (chain_en && sclk_rise && sync_lo
		|=> serial_data_out == $past(shreg[31]))
		else $error("Chain output wrong");
	bus_wait_a: assert property (req && !ack |-> avs_waitrequest ##1
		(!req || !avs_waitrequest))
		else $error("Bus answer late");

	frame_done_c: cover property (exec_std);
	frame_cut_c: cover property (abort);
	chain_exec_c: cover property (exec_chain);
	clear_hit_c: cover property (clr_fall);
endmodule

// File: logic/dsc_pkg.sv
// Purpose: Shared constants and types for the dual DAC serial command port
// Assumes: 32-bit frames, two channels, Avalon-MM register access
// Notes: Field positions are bit indices within the received frame
package dsc_pkg;
	localparam int NCH = 2;
	localparam int MAX_RES = 16;
	localparam int CNT_W = 6;
	localparam logic [5:0] LAST_BIT = 6'h1f;
	localparam logic [5:0] FULL_CNT = 6'h20;
	localparam int CMD_HI = 27;
	localparam int CMD_LO = 24;
	localparam int ADR_HI = 23;
	localparam int ADR_LO = 20;
	localparam int DATA_HI = 19;
	localparam int PD_HI = 9;
	localparam int PD_LO = 8;
	localparam int CHAIN_BIT = 1;
	localparam int AUX_W = 2;
	localparam int AUX_DIR_LO = 2;
	localparam int AUX_VAL_LO = 0;
	localparam int SEG_N = 15;
	localparam int LADDER_W = 12;

	typedef enum logic [3:0] {
		CMD_WR_IN = 4'h0,
		CMD_UPD = 4'h1,
		CMD_WR_ALL = 4'h2,
		CMD_WR_UPD = 4'h3,
		CMD_PWR = 4'h4,
		CMD_CLR_CODE = 4'h5,
		CMD_MASK = 4'h6,
		CMD_RESET = 4'h7,
		CMD_CHAIN = 4'h8,
		CMD_AUX = 4'h9,
		CMD_RSVD = 4'hf
	} dsc_cmd_e;

	localparam logic [3:0] ADDR_A = 4'h0;
	localparam logic [3:0] ADDR_B = 4'h1;
	localparam logic [3:0] ADDR_ALL = 4'hf;

	localparam logic [1:0] CLR_ZERO = 2'h0;
	localparam logic [1:0] CLR_MID = 2'h1;
	localparam logic [1:0] CLR_FULL = 2'h2;

	localparam int ADDR_W = 5;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h04;
	localparam logic [4:0] REG_CHAN_A = 5'h08;
	localparam logic [4:0] REG_CHAN_B = 5'h0c;
	localparam int CTRL_EN_BIT = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;

	localparam int CLK_PERIOD_NS = 25;
	localparam int SYNC_HI_MIN_NS = 15;
	localparam int SYNC_HI_CYC = (SYNC_HI_MIN_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// Pin synchroniser lanes and reset levels
	localparam int PIN_N = 5;
	localparam logic [4:0] PIN_RST = 5'h1b;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHIFT = 3'b010,
		ST_DONE = 3'b100
	} dsc_st_e;

	typedef struct packed {
		logic sync_n;
		logic sclk;
		logic sdin;
	} dsc_link_s;

	typedef struct packed {
		logic [1:0] pd_mode;
		logic [15:0] code;
		logic [14:0] segments;
		logic [11:0] ladder;
	} dsc_chan_s;
endpackage

// File: logic/dsc_therm_dec.sv
// Purpose: Registered thermometer decode of the top four code bits
// Assumes: Code is left aligned to sixteen bits
// Notes: Output lags the code by one clock
`timescale 1ns/1ps
module dsc_therm_dec (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [3:0] msb,
	output logic [14:0] seg
);
	logic [14:0] next_seg;

	always_comb begin
		for (int k = 0; k < dsc_pkg::SEG_N; k++) begin
			next_seg[k] = (msb > 4'(k));
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			seg <= 15'h0000;
		end else begin
			seg <= next_seg;
		end
	end

	therm_count_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$countones(seg) == 32'($past(msb)))
		else $error("Segment count differs from code");
endmodule

// File: dv/dsc_host_model.sv
// Purpose: Host side of the serial link, sends frames to the port
// Assumes: Driven from sys_clk edges; link clock period 8 sys_clk (200 ns)
// Notes: Link clock idles high; data line toggles while sync is high
`timescale 1ns/1ps
module dsc_host_model (
	input wire logic sys_clk,
	output dsc_pkg::dsc_link_s link
);
	initial begin
		link <= 3'b110;
	end
	// Released data line keeps changing
	always @(posedge sys_clk) begin
		if (link.sync_n) begin
			link.sdin <= ~link.sdin;
		end
	end
	// Sends the top n bits of f, then idles sync low and raises it
	task send(input logic [31:0] f, input int n);
		int i;
		@(posedge sys_clk);
		link.sync_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		for (i = 31; i > 31 - n; i--) begin
			link.sdin <= f[i];
			repeat (4) @(posedge sys_clk);
			link.sclk <= 1'b0;
			repeat (4) @(posedge sys_clk);
			link.sclk <= 1'b1;
		end
		repeat (4) @(posedge sys_clk);
		link.sync_n <= 1'b1;
		repeat (12) @(posedge sys_clk);
	endtask
endmodule

// File: dv/dual_dac_serial_command_port_bench.sv
// Purpose: Self-checking bench of the dual DAC serial command port
// Assumes: Avalon-MM slave with one wait state; host model on the link
// Notes: Expected codes follow from the commands sent
`timescale 1ns/1ps
module dual_dac_serial_command_port_bench;
	logic sys_clk;
	logic arst_n;
	dsc_pkg::dsc_link_s link;
	logic load_strobe_n;
	logic async_clear_n;
	logic serial_data_out;
	logic [1:0] aux_io_in;
	logic [1:0] aux_io_out;
	logic [1:0] aux_io_oe;
	dsc_pkg::dsc_chan_s [1:0] chan;
	logic [4:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [31:0] rd;
	int mismatches;
	int n_checks;
	int m;

	dsc_serial_port #(.RES(16), .POR_MID(1'b0)) dsc_serial_port_i (
		.sys_clk(sys_clk), .arst_n(arst_n), .link(link),
		.load_strobe_n(load_strobe_n), .async_clear_n(async_clear_n),
		.serial_data_out(serial_data_out), .aux_io_in(aux_io_in),
		.aux_io_out(aux_io_out), .aux_io_oe(aux_io_oe), .chan(chan),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
	);
	dsc_host_model dsc_host_model_i (.sys_clk(sys_clk), .link(link));

	initial begin
		sys_clk = 1'b0;
	end
	always #12.5 sys_clk = ~sys_clk;

	task results;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			mismatches++;
			results();
		end
	endtask
	task rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task cmd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d,
		input logic [3:0] p);
		dsc_host_model_i.send({4'h5, c, a, d, p}, 32);
	endtask
	task codes(input logic [15:0] ea, input logic [15:0] eb);
		chk("code_a", {16'h0, ea}, {16'h0, chan[0].code});
		chk("code_b", {16'h0, eb}, {16'h0, chan[1].code});
	endtask
	function logic [14:0] therm(input int n);
		return (15'h1 << n) - 15'h1;
	endfunction

	initial begin
		arst_n <= 1'b0;
		load_strobe_n <= 1'b1;
		async_clear_n <= 1'b1;
		aux_io_in <= 2'h0;
		avs_address <= 5'h00;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= 32'h0;
		mismatches = 0;
		n_checks = 0;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		// Reset state and register map
		rdc("ctrl", dsc_pkg::REG_CTRL, dsc_pkg::CTRL_RST);
		rdc("status", dsc_pkg::REG_STATUS, 32'h0);
		rdc("unmapped", 5'h10, 32'h0);
		bus(1'b1, dsc_pkg::REG_CHAN_A, 32'hffff_ffff);
		rdc("chan_a_ro", dsc_pkg::REG_CHAN_A, 32'h0);
		chk("sdo", 32'h0, {31'h0, serial_data_out});
		// Data commands
		cmd(dsc_pkg::CMD_WR_IN, dsc_pkg::ADDR_A, 16'h1234, 4'ha);
		codes(16'h0, 16'h0);
		rdc("chan_a", dsc_pkg::REG_CHAN_A, 32'h1234_0000);
		cmd(dsc_pkg::CMD_UPD, dsc_pkg::ADDR_A, 16'h0, 4'h0);
		codes(16'h1234, 16'h0);
		chk("ladder", 32'h234, {20'h0, chan[0].ladder});
		chk("seg_a", {17'h0, therm(1)}, {17'h0, chan[0].segments});
		cmd(dsc_pkg::CMD_WR_UPD, dsc_pkg::ADDR_B, 16'habcd, 4'ha);
		codes(16'h1234, 16'habcd);
		chk("seg_b", {17'h0, therm(10)}, {17'h0, chan[1].segments});
		cmd(dsc_pkg::CMD_WR_ALL, dsc_pkg::ADDR_A, 16'h5555, 4'ha);
		codes(16'h5555, 16'habcd);
		// Cut short frame
		dsc_host_model_i.send({8'h03, 4'h0, 16'h9999, 4'h0}, 20);
		codes(16'h5555, 16'habcd);
		bus(1'b0, dsc_pkg::REG_STATUS, 32'h0);
		chk("aborted", 32'h1, {24'h0, rd[23:16]});
		// Reserved command and address, then both channels
		cmd(dsc_pkg::CMD_RSVD, dsc_pkg::ADDR_A, 16'h1111, 4'ha);
		cmd(dsc_pkg::CMD_WR_UPD, 4'h2, 16'h2222, 4'ha);
		codes(16'h5555, 16'habcd);
		cmd(dsc_pkg::CMD_WR_UPD, dsc_pkg::ADDR_ALL, 16'h8000, 4'ha);
		codes(16'h8000, 16'h8000);
		// Power modes, both channels selected
		for (m = 1; m < 5; m++) begin
			cmd(dsc_pkg::CMD_PWR, 4'h0, {10'h0, 2'(m % 4), 4'h0}, 4'h3);
			chk("pd_a", 32'(m % 4), {30'h0, chan[0].pd_mode});
			chk("pd_b", 32'(m % 4), {30'h0, chan[1].pd_mode});
		end
		// Strobe with channel A masked
		cmd(dsc_pkg::CMD_MASK, 4'h0, 16'h0, 4'h1);
		cmd(dsc_pkg::CMD_WR_IN, dsc_pkg::ADDR_A, 16'h0f0f, 4'ha);
		cmd(dsc_pkg::CMD_WR_IN, dsc_pkg::ADDR_B, 16'hf0f0, 4'ha);
		load_strobe_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		load_strobe_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		codes(16'h8000, 16'hf0f0);
		cmd(dsc_pkg::CMD_UPD, dsc_pkg::ADDR_ALL, 16'h0, 4'h0);
		codes(16'h0f0f, 16'hf0f0);
		// Clear to full scale, then to midscale
		cmd(dsc_pkg::CMD_CLR_CODE, 4'h0, 16'h0, {2'h0, dsc_pkg::CLR_FULL});
		bus(1'b0, dsc_pkg::REG_STATUS, 32'h0);
		chk("clr_code", 32'h2, {30'h0, rd[7:6]});
		async_clear_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		codes(16'hffff, 16'hffff);
		rdc("chan_a_clr", dsc_pkg::REG_CHAN_A, 32'hffff_ffff);
		async_clear_n <= 1'b1;
		cmd(dsc_pkg::CMD_CLR_CODE, 4'h0, 16'h0, {2'h0, dsc_pkg::CLR_MID});
		async_clear_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		codes(16'h8000, 16'h8000);
		async_clear_n <= 1'b1;
		// Aux pins
		aux_io_in <= 2'h1;
		cmd(dsc_pkg::CMD_AUX, 4'h0, 16'h0, 4'he);
		chk("aux_oe", 32'h3, {30'h0, aux_io_oe});
		chk("aux_out", 32'h2, {30'h0, aux_io_out});
		bus(1'b0, dsc_pkg::REG_STATUS, 32'h0);
		chk("aux_in", 32'h1, {30'h0, rd[13:12]});
		// Chain enable, then software reset
		cmd(dsc_pkg::CMD_CHAIN, 4'h0, 16'h0, 4'h2);
		bus(1'b0, dsc_pkg::REG_STATUS, 32'h0);
		chk("chain_en", 32'h1, {31'h0, rd[0]});
		chk("frames", 32'h13, {24'h0, rd[31:24]});
		cmd(dsc_pkg::CMD_RESET, 4'h0, 16'h0, 4'h0);
		codes(16'h0, 16'h0);
		bus(1'b0, dsc_pkg::REG_STATUS, 32'h0);
		chk("chain_off", 32'h0, {31'h0, rd[0]});
		chk("frames_chain", 32'h14, {24'h0, rd[31:24]});
		// Port disabled ignores frames
		bus(1'b1, dsc_pkg::REG_CTRL, 32'h0);
		cmd(dsc_pkg::CMD_WR_UPD, dsc_pkg::ADDR_A, 16'h7777, 4'ha);
		codes(16'h0, 16'h0);
		bus(1'b1, dsc_pkg::REG_CTRL, 32'h1);
		rdc("ctrl_on", dsc_pkg::REG_CTRL, 32'h1);
		results();
	end
endmodule
